// ### hdl/irq_rst_pkg.sv
package irq_rst_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] INT_STAT_OFS = 8'h08;
    localparam logic [7:0] INT_CLR_OFS = 8'h0C;
    localparam logic [7:0] INT_EN_OFS = 8'h10;
    // ----------------------------------------------------------------
    // control fields and reset value
    // ----------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_NEG_BIT = 1;
    localparam int CTRL_POS_BIT = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    // ----------------------------------------------------------------
    // trigger codes, {trigger_select_positive, trigger_select_negative}
    // ----------------------------------------------------------------
    localparam logic [1:0] TRIG_LOW = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_RISE = 2'h2;
    localparam logic [1:0] TRIG_BOTH = 2'h3;
    // ----------------------------------------------------------------
    // event bits of the sticky status
    // ----------------------------------------------------------------
    localparam int EV_EXT = 0;
    localparam int EV_WDOG = 1;
    localparam int EV_REJECT = 2;
    localparam int EV_W = 3;
    // ----------------------------------------------------------------
    // status fields
    // ----------------------------------------------------------------
    localparam int ST_PEND_BIT = 0;
    localparam int ST_PIN_BIT = 1;
    localparam int ST_DRIVE_BIT = 2;
    localparam int ST_RESET_BIT = 3;
    localparam int ST_WAIT_BIT = 4;
    // ----------------------------------------------------------------
    // vectors and timing
    // ----------------------------------------------------------------
    localparam logic [15:0] VEC_EXT = 16'h1FFA;
    localparam logic [15:0] VEC_RESET = 16'h1FFE;
    localparam int CLK_MHZ = 250;
    localparam int RST_DRIVE_NS = 64;
    localparam int RST_DRIVE_CYC = (RST_DRIVE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    // ----------------------------------------------------------------
    // reset pin driver states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {RP_IDLE, RP_DRIVE, RP_WAIT_HIGH} rpin_state_t;
endpackage

// ### hdl/irq_detect_if.sv
`timescale 1ns/1ps
interface irq_detect_if;
    logic pin_level;
    logic [1:0] trig_sel;
    logic enable;
    logic clear_hist;
    logic trig_event;
    modport ctl (output pin_level, output trig_sel, output enable, output clear_hist, input trig_event);
    modport det (input pin_level, input trig_sel, input enable, input clear_hist, output trig_event);
endinterface

// ### hdl/irq_detect.sv
`timescale 1ns/1ps
module irq_detect (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    irq_detect_if.det dif
);
    import irq_rst_pkg::*;

    logic prev_reg;
    logic event_reg;
    logic hit;

    // ----------------------------------------------------------------
    // trigger condition
    // ----------------------------------------------------------------
    always_comb begin
        case (dif.trig_sel)
            TRIG_LOW: hit = !dif.pin_level;
            TRIG_FALL: hit = prev_reg && !dif.pin_level;
            TRIG_RISE: hit = !prev_reg && dif.pin_level;
            TRIG_BOTH: hit = prev_reg != dif.pin_level;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prev_reg <= 1'b1;
        end else if (ce) begin
            prev_reg <= dif.clear_hist ? 1'b1 : dif.pin_level;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            event_reg <= 1'b0;
        end else if (ce) begin
            event_reg <= hit && dif.enable && !dif.clear_hist;
        end
    end

    assign dif.trig_event = event_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_rise_detect: assert property (
        ce && dif.enable && !dif.clear_hist && dif.trig_sel == TRIG_RISE && !prev_reg && dif.pin_level
        |=> dif.trig_event) else $error("rising edge not detected");
    a_fall_detect: assert property (
        ce && dif.enable && !dif.clear_hist && dif.trig_sel == TRIG_FALL && prev_reg && !dif.pin_level
        |=> dif.trig_event) else $error("falling edge not detected");
endmodule

// ### hdl/ext_irq_reset_pins.sv
`timescale 1ns/1ps
// Functional notes
// - two trigger-select bits choose one of four external trigger conditions.
// - clearing the enable bit stops the pin from raising any request.
// - trigger bits are written only while the processor mask input is set.
// - a changed trigger option clears any pending external request.
// - low reset pin puts control, pending request and vector in start-up state while held; interrupt status and enable keep their values.
// - watchdog reset drives the reset pin low as open drain.
// - external request points vector at 1FFA, reset at 1FFE.
// - external request, reset pin, timer or serial request end wait.
module ext_irq_reset_pins #(
    parameter int DRIVE_CYC = irq_rst_pkg::RST_DRIVE_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_pin,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    input wire logic watchdog_reset_source,
    input wire logic cpu_imask,
    input wire logic int_ack,
    input wire logic wait_enter,
    input wire logic timer_irq,
    input wire logic serial_irq,
    output logic ext_int_req,
    output logic [15:0] vector_addr,
    output logic sys_reset,
    output logic wait_wake,
    output logic irq_out
);
    import irq_rst_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    irq_detect_if dif();
    logic [CTRL_W-1:0] ctrl_reg;
    logic pend_reg;
    logic [EV_W-1:0] int_stat_reg;
    logic [EV_W-1:0] int_en_reg;
    logic [EV_W-1:0] int_stat_next;
    logic irq_reg;
    rpin_state_t rp_state_reg;
    logic [CNT_W-1:0] drive_cnt_reg;
    logic oe_reg;
    logic sysrst_reg;
    logic [15:0] vec_reg;
    logic in_wait_reg;
    logic wake_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic in_reset;
    logic acc;
    logic apb_wr;
    logic wr_ctrl;
    logic [1:0] cur_trig;
    logic [1:0] new_trig;
    logic opt_change;
    logic opt_reject;
    logic wd_fire;
    logic wake_cond;

    function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic known(input logic [7:0] a);
        return at(a, CTRL_OFS) || at(a, STAT_OFS) || at(a, INT_STAT_OFS) || at(a, INT_CLR_OFS) || at(a, INT_EN_OFS);
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign in_reset = !rst_pin_in;
    assign acc = psel && penable && pready_reg;
    assign apb_wr = acc && pwrite;
    assign wr_ctrl = apb_wr && at(paddr, CTRL_OFS) && pstrb[0];
    assign cur_trig = {ctrl_reg[CTRL_POS_BIT], ctrl_reg[CTRL_NEG_BIT]};
    assign new_trig = {pwdata[CTRL_POS_BIT], pwdata[CTRL_NEG_BIT]};
    assign opt_change = wr_ctrl && cpu_imask && new_trig != cur_trig;
    assign opt_reject = wr_ctrl && !cpu_imask && new_trig != cur_trig;
    assign wd_fire = watchdog_reset_source && rp_state_reg == RP_IDLE;
    assign wake_cond = in_wait_reg && (pend_reg || in_reset || timer_irq || serial_irq);

    // ----------------------------------------------------------------
    // trigger detector
    // ----------------------------------------------------------------
    assign dif.pin_level = irq_pin;
    assign dif.trig_sel = cur_trig;
    assign dif.enable = ctrl_reg[CTRL_EN_BIT] && !in_reset;
    assign dif.clear_hist = opt_change;

    irq_detect u_detect (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .dif(dif)
    );

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (ce) begin
            if (in_reset) begin
                ctrl_reg <= CTRL_RESET;
            end else if (wr_ctrl) begin
                ctrl_reg[CTRL_EN_BIT] <= pwdata[CTRL_EN_BIT];
                if (cpu_imask) begin
                    ctrl_reg[CTRL_POS_BIT] <= pwdata[CTRL_POS_BIT];
                    ctrl_reg[CTRL_NEG_BIT] <= pwdata[CTRL_NEG_BIT];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // pending request latch
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= 1'b0;
        end else if (ce) begin
            if (in_reset || opt_change) begin
                pend_reg <= 1'b0;
            end else if (dif.trig_event) begin
                pend_reg <= 1'b1;
            end else if (int_ack) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // vector, reset and wait outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vec_reg <= VEC_RESET;
            sysrst_reg <= 1'b1;
        end else if (ce) begin
            sysrst_reg <= in_reset;
            if (in_reset) begin
                vec_reg <= VEC_RESET;
            end else if (pend_reg) begin
                vec_reg <= VEC_EXT;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            in_wait_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else if (ce) begin
            wake_reg <= wake_cond;
            if (wake_cond) begin
                in_wait_reg <= 1'b0;
            end else if (wait_enter) begin
                in_wait_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // reset pin open-drain driver
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rp_state_reg <= RP_IDLE;
            drive_cnt_reg <= '0;
            oe_reg <= 1'b0;
        end else if (ce) begin
            case (rp_state_reg)
                RP_IDLE: begin
                    if (watchdog_reset_source) begin
                        rp_state_reg <= RP_DRIVE;
                        drive_cnt_reg <= CNT_W'(DRIVE_CYC - 1);
                        oe_reg <= 1'b1;
                    end
                end
                RP_DRIVE: begin
                    if (drive_cnt_reg == '0) begin
                        rp_state_reg <= RP_WAIT_HIGH;
                        oe_reg <= 1'b0;
                    end else begin
                        drive_cnt_reg <= drive_cnt_reg - 1'b1;
                    end
                end
                RP_WAIT_HIGH: begin
                    if (rst_pin_in) begin
                        rp_state_reg <= RP_IDLE;
                    end
                end
                default: begin
                    rp_state_reg <= RP_IDLE;
                    oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, enable and output
    // ----------------------------------------------------------------
    always_comb begin
        int_stat_next = int_stat_reg;
        if (apb_wr && at(paddr, INT_CLR_OFS) && pstrb[0]) begin
            int_stat_next = int_stat_next & ~pwdata[EV_W-1:0];
        end
        int_stat_next[EV_EXT] = int_stat_next[EV_EXT] | dif.trig_event;
        int_stat_next[EV_WDOG] = int_stat_next[EV_WDOG] | wd_fire;
        int_stat_next[EV_REJECT] = int_stat_next[EV_REJECT] | opt_reject;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            int_stat_reg <= '0;
            int_en_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce) begin
            int_stat_reg <= int_stat_next;
            irq_reg <= |(int_stat_next & int_en_reg);
            if (apb_wr && at(paddr, INT_EN_OFS) && pstrb[0]) begin
                int_en_reg <= pwdata[EV_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // apb slave, one wait state
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else if (ce) begin
            pready_reg <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !known(paddr);
            prdata_reg <= '0;
            if (psel && penable && !pready_reg && !pwrite) begin
                case (paddr)
                    CTRL_OFS: prdata_reg <= {{(32 - CTRL_W){1'b0}}, ctrl_reg};
                    STAT_OFS: prdata_reg <= {27'h0, in_wait_reg, sysrst_reg, oe_reg, rst_pin_in, pend_reg};
                    INT_STAT_OFS: prdata_reg <= {{(32 - EV_W){1'b0}}, int_stat_reg};
                    INT_EN_OFS: prdata_reg <= {{(32 - EV_W){1'b0}}, int_en_reg};
                    default: prdata_reg <= '0;
                endcase
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = oe_reg;
    assign ext_int_req = pend_reg;
    assign vector_addr = vec_reg;
    assign sys_reset = sysrst_reg;
    assign wait_wake = wake_reg;
    assign irq_out = irq_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_wd_fire;
        ce && rp_state_reg == RP_IDLE && watchdog_reset_source;
    endsequence
    sequence s_drive_held;
        rst_pin_oe [*2];
    endsequence

    a_opt_locked: assert property (ce && wr_ctrl && !cpu_imask && !in_reset
        |=> cur_trig == $past(cur_trig)) else $error("trigger bits changed while unmasked");
    a_opt_clears: assert property (ce && opt_change |=> !ext_int_req)
        else $error("option change left request pending");
    a_disable_quiet: assert property (ce && !ctrl_reg[CTRL_EN_BIT] |=> !dif.trig_event)
        else $error("disabled pin raised a request");
    a_pend_sets: assert property (ce && dif.trig_event && !opt_change && !in_reset |=> ext_int_req)
        else $error("event did not set pending");
    a_pin_reset: assert property (ce && in_reset |=> sys_reset && !ext_int_req && vector_addr == VEC_RESET)
        else $error("reset pin not obeyed");
    a_wd_drive: assert property (s_wd_fire |=> s_drive_held ##0 rst_pin_out == 1'b0)
        else $error("watchdog reset not driven on pin");
    a_ext_vector: assert property (ce && !in_reset && ext_int_req |=> vector_addr == VEC_EXT)
        else $error("external vector wrong");
    a_wait_wake: assert property (ce && in_wait_reg && (timer_irq || serial_irq || ext_int_req)
        |=> wait_wake && !in_wait_reg) else $error("wait not ended");
endmodule

// ### sim/irq_rst_world.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// interrupt source and board reset circuit
// ----------------------------------------------------------------
module irq_rst_world #(
    parameter int RC_CYC = 3
) (
    input wire logic core_clk,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe,
    input wire logic board_rst,
    input wire logic irq_drive,
    output logic irq_pin,
    output logic rst_pin_in
);
    int rc_cnt = 0;
    // board reset releases slowly through its rc
    always @(posedge core_clk) begin
        if (board_rst) begin
            rc_cnt <= RC_CYC;
        end else if (rc_cnt != 0) begin
            rc_cnt <= rc_cnt - 1;
        end
    end
    // open drain wire with pull-up
    assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || board_rst || rc_cnt != 0);
    assign irq_pin = irq_drive;
endmodule

// ### sim/ext_irq_reset_pins_tb.sv
`timescale 1ns/1ps
module ext_irq_reset_pins_tb;
    import irq_rst_pkg::*;
    localparam int DRIVE = 4;
    logic core_clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, irq_pin, rst_pin_in, rst_pin_out, rst_pin_oe, e, en, fr, to, saw;
    logic watchdog_reset_source = 0, cpu_imask = 1, int_ack = 0, wait_enter = 0;
    logic timer_irq = 0, serial_irq = 0, board_rst = 0, irq_drive = 1;
    logic ext_int_req, sys_reset, wait_wake, irq_out;
    logic [15:0] vector_addr;
    logic [1:0] code;
    int n_fail = 0, checks = 0, n;
    always #2 core_clk = ~core_clk;
    ext_irq_reset_pins #(.DRIVE_CYC(DRIVE)) dut (.core_clk(core_clk), .resetn(resetn), .ce(ce),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_pin(irq_pin), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .watchdog_reset_source(watchdog_reset_source),
        .cpu_imask(cpu_imask), .int_ack(int_ack), .wait_enter(wait_enter), .timer_irq(timer_irq),
        .serial_irq(serial_irq), .ext_int_req(ext_int_req), .vector_addr(vector_addr),
        .sys_reset(sys_reset), .wait_wake(wait_wake), .irq_out(irq_out));
    irq_rst_world world (.core_clk(core_clk), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .board_rst(board_rst), .irq_drive(irq_drive), .irq_pin(irq_pin), .rst_pin_in(rst_pin_in));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (n_fail == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge core_clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w >= 50) begin
            n_fail++;
            complete_run();
        end
    endtask
    task automatic ack();
        @(posedge core_clk);
        int_ack <= 1'b1;
        @(posedge core_clk);
        int_ack <= 1'b0;
    endtask
    function automatic logic trig(input logic [1:0] c, input logic f, input logic t);
        case (c)
            TRIG_LOW: return !t;
            TRIG_FALL: return f && !t;
            TRIG_RISE: return !f && t;
            default: return f != t;
        endcase
    endfunction
    initial begin
        cyc(20000);
        n_fail++;
        complete_run();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(18410));
        cyc(3);
        resetn <= 1'b1;
        #1 chk(32'(vector_addr), 32'(VEC_RESET));
        chk(32'(sys_reset), 32'h1);
        apb(0, CTRL_OFS, 0);
        chk(q, 32'(CTRL_RESET));
        apb(0, 8'h14, 0);
        chk({q[30:0], e}, 32'h1);
        cpu_imask <= 1'b0;
        apb(1, CTRL_OFS, 32'h7);
        apb(0, CTRL_OFS, 0);
        chk(q, 32'(CTRL_RESET));
        apb(0, INT_STAT_OFS, 0);
        chk(32'(q[EV_REJECT]), 32'h1);
        cpu_imask <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            code = i[1:0];
            en = (i < 4) ? 1'b1 : 1'($urandom % 2);
            fr = (code == TRIG_LOW) ? 1'b1 : 1'($urandom % 2);
            to = 1'($urandom % 2);
            irq_drive <= fr;
            apb(1, CTRL_OFS, {29'h0, code, en});
            cyc(4);
            ack();
            cyc(4);
            irq_drive <= to;
            cyc(4);
            #1 chk(32'(ext_int_req), 32'(en & trig(code, fr, to)));
            if (ext_int_req === 1'b1) chk(32'(vector_addr), 32'(VEC_EXT));
        end
        irq_drive <= 1'b1;
        apb(1, CTRL_OFS, {29'h0, TRIG_FALL, 1'b1});
        cyc(4);
        ack();
        irq_drive <= 1'b0;
        cyc(4);
        apb(1, CTRL_OFS, {29'h0, TRIG_FALL, 1'b1});
        cyc(2);
        #1 chk(32'(ext_int_req), 32'h1);
        apb(1, CTRL_OFS, {29'h0, TRIG_RISE, 1'b1});
        cyc(2);
        #1 chk(32'(ext_int_req), 32'h0);
        irq_drive <= 1'b1;
        cyc(4);
        ack();
        cyc(3);
        #1 chk(32'(ext_int_req), 32'h0);
        apb(1, INT_EN_OFS, 32'h1);
        cyc(2);
        #1 chk(32'(irq_out), 32'h1);
        apb(1, INT_EN_OFS, 32'h0);
        cyc(2);
        #1 chk(32'(irq_out), 32'h0);
        apb(1, INT_CLR_OFS, 32'h7);
        apb(0, INT_STAT_OFS, 0);
        chk(q, 32'h0);
        apb(0, INT_CLR_OFS, 0);
        chk(q, 32'h0);
        apb(1, CTRL_OFS, {29'h0, TRIG_FALL, 1'b1});
        cyc(4);
        ack();
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk);
            wait_enter <= 1'b1;
            @(posedge core_clk);
            wait_enter <= 1'b0;
            cyc(3);
            #1 chk(32'(wait_wake), 32'h0);
            @(posedge core_clk);
            timer_irq <= (s == 0);
            serial_irq <= (s == 1);
            if (s == 2) irq_drive <= 1'b0;
            board_rst <= (s == 3);
            n = 0;
            saw = 0;
            while (n < 8) begin
                @(posedge core_clk);
                board_rst <= 1'b0;
                #1 saw = saw | wait_wake;
                n++;
            end
            chk(32'(saw), 32'h1);
            timer_irq <= 1'b0;
            serial_irq <= 1'b0;
            if (s == 2) ack();
        end
        apb(0, CTRL_OFS, 0);
        chk(q, 32'(CTRL_RESET));
        irq_drive <= 1'b1;
        cyc(6);
        watchdog_reset_source <= 1'b1;
        n = 0;
        saw = 0;
        for (int k = 0; k < DRIVE + 6; k++) begin
            @(posedge core_clk);
            watchdog_reset_source <= 1'b0;
            #1 if (rst_pin_oe === 1'b1) n++;
            saw = saw | sys_reset;
        end
        chk(32'(n), 32'(DRIVE));
        chk(32'(rst_pin_out), 32'h0);
        chk(32'(saw), 32'h1);
        apb(0, INT_STAT_OFS, 0);
        chk(32'(q[EV_WDOG]), 32'h1);
        apb(0, STAT_OFS, 0);
        chk(q, 32'h2);
        ce <= 1'b0;
        irq_drive <= 1'b0;
        cyc(4);
        #1 chk(32'(ext_int_req), 32'h0);
        @(posedge core_clk);
        ce <= 1'b1;
        cyc(3);
        #1 chk(32'(ext_int_req), 32'h1);
        complete_run();
    end
endmodule
